// ===== hw/ieh_core.sv
`timescale 1ns/10ps
// Contract
// - interrupt only when enabled, on listed events
// - status stable while interrupt awaits firmware
// - slave receive byte interrupts, flags first byte
// - slave receive stop sets stop flag, interrupts
// - ack cleared during receive suppresses stop detection
// - slave transmit byte interrupts, ack shows master
// - master transmit interrupts after each sent byte
// - clearing role in master transmit issues stop
// - master receive interrupts after each byte
// - role cleared with proceed in receive stops
// - lost arbitration clears role, waits stop, interrupts
// - busy cleared before each byte interrupt
// - hardware may change registers while busy
// - interrupt uses last vector, lowest priority
module ieh_core (
   // system clock, reset, enable
   input  wire logic                clk_sys,
   input  wire logic                rst_b,
   input  wire logic                ce,
   // firmware side
   input  wire logic                ctrlWr,
   input  wire ieh_pkg::ieh_ctrl_t  ctrlIn,
   input  wire logic                dataWr,
   input  wire logic [7:0]          dataIn,
   input  wire logic                intEnable,
   output ieh_pkg::ieh_status_t     status,
   output logic [7:0]               dataOut,
   output logic                     irq,
   output logic [15:0]              irqVector,
   // link side
   input  wire logic                clk_link,
   input  wire ieh_pkg::ieh_evt_t   linkEvt,
   input  wire logic [7:0]          linkRxByte,
   input  wire logic                linkAckIn,
   output logic                     sclHoldLow,
   output logic                     stopIssue,
   output logic [7:0]               txByte,
   output logic                     ackOut,
   output logic                     xmitOut
);

   logic [ieh_pkg::EVT_W-1:0] linkTgl;
   logic [ieh_pkg::EVT_W-1:0] evtSync;
   logic [7:0]                rxHold;
   logic                      ackHold;
   ieh_pkg::ieh_evt_t         evtPulse;
   ieh_pkg::ieh_ctrl_t        ctrl_reg, ctrl_next;
   ieh_pkg::ieh_mode_t        mode_reg, mode_next;
   logic [ieh_pkg::EVT_W-1:0] evtSeen_reg, evtSeen_next;
   logic [7:0]                data_reg, data_next;
   logic                      addrFirst_reg, addrFirst_next;
   logic                      stopSeen_reg, stopSeen_next;
   logic                      arbFlag_reg, arbFlag_next;
   logic                      firstByte_reg, firstByte_next;
   logic                      noStop_reg, noStop_next;
   logic                      irqPend_reg, irqPend_next;
   logic                      irq_reg, irq_next;
   logic                      stopReq_reg, stopReq_next;
   logic                      grantTgl_reg, grantTgl_next;
   logic [15:0]               vec_reg;

   ////////////////////////////////////////////////////////////////////////////
   // link domain and crossings

   ieh_link uLink (
      .clk_link   (clk_link),
      .rst_b      (rst_b),
      .evt        (linkEvt),
      .rxByte     (linkRxByte),
      .ackIn      (linkAckIn),
      .ceSys      (ce),
      .grantTgl   (grantTgl_reg),
      .stopReq    (stopReq_reg),
      .evtTgl     (linkTgl),
      .rxHold     (rxHold),
      .ackHold    (ackHold),
      .sclHoldLow (sclHoldLow),
      .stopIssue  (stopIssue)
   );

   // event toggles cross on two flops; byte and ack are held long enough
   ieh_sync #(.W(ieh_pkg::EVT_W)) uEvtSync (
      .clk   (clk_sys),
      .rst_b (rst_b),
      .d     (linkTgl),
      .q     (evtSync)
   );

   // a changed toggle is one event
   assign evtPulse = ieh_pkg::ieh_evt_t'(evtSync ^ evtSeen_reg);

   ////////////////////////////////////////////////////////////////////////////
   // handshake state

   // firmware is applied first and hardware after, so a hardware update wins a firmware write
   always_comb begin
      ctrl_next      = ctrl_reg;
      mode_next      = mode_reg;
      evtSeen_next   = evtSeen_reg;
      data_next      = data_reg;
      addrFirst_next = addrFirst_reg;
      stopSeen_next  = stopSeen_reg;
      arbFlag_next   = arbFlag_reg;
      firstByte_next = firstByte_reg;
      noStop_next    = noStop_reg;
      irqPend_next   = irqPend_reg;
      irq_next       = irq_reg;
      stopReq_next   = stopReq_reg;
      grantTgl_next  = grantTgl_reg;
      if (ce) begin
         evtSeen_next = evtSync;
         if (ctrlWr) begin
            // dropping the role in master transmit, or in master receive with proceed, asks the bus engine for a stop
            if (ctrl_reg.controllerRoleSelect && !ctrlIn.controllerRoleSelect &&
                (mode_reg == ieh_pkg::IEH_MST_TX ||
                 (mode_reg == ieh_pkg::IEH_MST_RX && ctrlIn.proceed))) begin
               stopReq_next = 1'b1;
            end
            if (mode_reg == ieh_pkg::IEH_SLV_RX && !ctrlIn.ack) begin
               noStop_next = 1'b1;
            end
            ctrl_next      = ctrlIn;
            irqPend_next   = 1'b0;
            addrFirst_next = 1'b0;
            stopSeen_next  = 1'b0;
            arbFlag_next   = 1'b0;
            if (ctrlIn.proceed) begin
               grantTgl_next = ~grantTgl_reg;
               if (mode_reg != ieh_pkg::IEH_IDLE && mode_reg != ieh_pkg::IEH_ARB_WAIT) begin
                  if (ctrlIn.controllerRoleSelect) begin
                     mode_next = ctrlIn.xmit ? ieh_pkg::IEH_MST_TX : ieh_pkg::IEH_MST_RX;
                  end else begin
                     mode_next = ctrlIn.xmit ? ieh_pkg::IEH_SLV_TX : ieh_pkg::IEH_SLV_RX;
                  end
               end
            end
            // a requested stop leaves the controller idle, not in a slave mode
            if (stopReq_next) mode_next = ieh_pkg::IEH_IDLE;
         end
         if (dataWr) data_next = dataIn;
         if (evtPulse.start) begin
            firstByte_next = 1'b1;
            noStop_next    = 1'b0;
            mode_next      = ctrl_next.controllerRoleSelect ? ieh_pkg::IEH_MST_TX
                                                            : ieh_pkg::IEH_SLV_RX;
         end
         if (evtPulse.byteDone) begin
            ctrl_next.proceed = 1'b0;
            irqPend_next      = 1'b1;
            firstByte_next    = 1'b0;
            case (mode_reg)
               ieh_pkg::IEH_SLV_RX: begin
                  addrFirst_next = firstByte_reg;
                  data_next      = rxHold;
               end
               ieh_pkg::IEH_SLV_TX: begin
                  ctrl_next.ack = ackHold;
               end
               ieh_pkg::IEH_MST_RX: begin
                  data_next = rxHold;
               end
               default: begin
               end
            endcase
         end
         if (evtPulse.arbLost) begin
            ctrl_next.controllerRoleSelect = 1'b0;
            arbFlag_next                   = 1'b1;
            mode_next                      = ieh_pkg::IEH_ARB_WAIT;
         end
         if (evtPulse.stop) begin
            if (mode_reg == ieh_pkg::IEH_SLV_RX && !noStop_reg) begin
               stopSeen_next = 1'b1;
               irqPend_next  = 1'b1;
            end
            if (mode_reg == ieh_pkg::IEH_ARB_WAIT) irqPend_next = 1'b1;
            stopReq_next = 1'b0;
            mode_next    = ieh_pkg::IEH_IDLE;
         end
         // pending stays, only the pin is gated by the enable
         irq_next = irqPend_reg && intEnable;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_reg      <= ieh_pkg::CTRL_RST;
         mode_reg      <= ieh_pkg::IEH_IDLE;
         evtSeen_reg   <= '0;
         data_reg      <= ieh_pkg::DATA_RST;
         addrFirst_reg <= 1'b0;
         stopSeen_reg  <= 1'b0;
         arbFlag_reg   <= 1'b0;
         firstByte_reg <= 1'b0;
         noStop_reg    <= 1'b0;
         irqPend_reg   <= 1'b0;
         irq_reg       <= 1'b0;
         stopReq_reg   <= 1'b0;
         grantTgl_reg  <= 1'b0;
         vec_reg       <= ieh_pkg::IRQ_VECTOR;
      end else begin
         ctrl_reg      <= ctrl_next;
         mode_reg      <= mode_next;
         evtSeen_reg   <= evtSeen_next;
         data_reg      <= data_next;
         addrFirst_reg <= addrFirst_next;
         stopSeen_reg  <= stopSeen_next;
         arbFlag_reg   <= arbFlag_next;
         firstByte_reg <= firstByte_next;
         noStop_reg    <= noStop_next;
         irqPend_reg   <= irqPend_next;
         irq_reg       <= irq_next;
         stopReq_reg   <= stopReq_next;
         grantTgl_reg  <= grantTgl_next;
         vec_reg       <= vec_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all straight from flops

   // busy is the proceed bit; hardware may move it while a transfer runs
   assign status    = {addrFirst_reg, stopSeen_reg, arbFlag_reg, ctrl_reg.ack,
                       ctrl_reg.xmit, ctrl_reg.controllerRoleSelect,
                       ctrl_reg.proceed};
   assign dataOut   = data_reg;
   assign irq       = irq_reg;
   assign irqVector = vec_reg;
   assign txByte    = data_reg;  // changes on a data write or a received byte, even while the link waits for a grant
   assign ackOut    = ctrl_reg.ack;
   assign xmitOut   = ctrl_reg.xmit;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cbSys @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   sequence byteIn(ieh_pkg::ieh_mode_t m);
      ce && evtPulse.byteDone && mode_reg == m;
   endsequence

   sequence stopIn(ieh_pkg::ieh_mode_t m);
      ce && evtPulse.stop && mode_reg == m;
   endsequence

   irqEnable_a: assert property ($rose(irq) |-> $past(intEnable) && $past(irqPend_reg))
      else $error("interrupt without enable");

   statusHold_a: assert property (irqPend_reg && (!ce || (!ctrlWr && evtPulse == '0))
      |=> $stable(status))
      else $error("status moved while interrupt waits");

   addrFirst_a: assert property (byteIn(ieh_pkg::IEH_SLV_RX) and firstByte_reg
      |=> addrFirst_reg && irqPend_reg)
      else $error("first byte not flagged");

   stopIrq_a: assert property (stopIn(ieh_pkg::IEH_SLV_RX) and !noStop_reg
      |=> stopSeen_reg ##1 (irq || !$past(intEnable)))
      else $error("slave stop not reported");

   noStop_a: assert property (stopIn(ieh_pkg::IEH_SLV_RX) and noStop_reg
      |=> !$rose(stopSeen_reg))
      else $error("stop reported after nack");

   slvTxAck_a: assert property (byteIn(ieh_pkg::IEH_SLV_TX)
      |=> status.ack == $past(ackHold) && irqPend_reg)
      else $error("master ack not shown");

   mstByte_a: assert property ((byteIn(ieh_pkg::IEH_MST_TX) or byteIn(ieh_pkg::IEH_MST_RX))
      |=> irqPend_reg && !status.busy)
      else $error("master byte not reported");

   busyClr_a: assert property (ce && evtPulse.byteDone |=> !status.busy)
      else $error("busy still set at byte interrupt");

   stopReq_a: assert property (ce && ctrlWr && mode_reg == ieh_pkg::IEH_MST_TX &&
      ctrl_reg.controllerRoleSelect && !ctrlIn.controllerRoleSelect && !evtPulse.stop
      |=> stopReq_reg)
      else $error("no stop request on role drop");

   arbLost_a: assert property (ce && evtPulse.arbLost && !evtPulse.stop
      |=> !status.controllerRoleSelect && arbFlag_reg && mode_reg == ieh_pkg::IEH_ARB_WAIT)
      else $error("arbitration loss not taken");

   arbIrq_a: assert property (stopIn(ieh_pkg::IEH_ARB_WAIT) |=> irqPend_reg
      ##0 mode_reg == ieh_pkg::IEH_IDLE)
      else $error("arbitration interrupt not raised at stop");

endmodule // ieh_core

// ===== inc/ieh_pkg.sv
package ieh_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // widths, reset values and the fixed vector

   localparam int          DATA_W      = 8;
   localparam int          EVT_W       = 4;
   localparam int          LINK_SYNC_W = 3;
   localparam logic [7:0]  DATA_RST    = 8'h00;
   localparam logic [15:0] IRQ_VECTOR  = 16'h0018;  // last entry, lowest priority

   ////////////////////////////////////////////////////////////////////////////
   // types

   // controller modes, binary codes written out
   typedef enum logic [2:0] {
      IEH_IDLE     = 3'h0,
      IEH_SLV_RX   = 3'h1,
      IEH_SLV_TX   = 3'h2,
      IEH_MST_TX   = 3'h3,
      IEH_MST_RX   = 3'h4,
      IEH_ARB_WAIT = 3'h5
   } ieh_mode_t;

   // firmware control word
   typedef struct packed {
      logic ack;
      logic xmit;
      logic controllerRoleSelect;
      logic proceed;
   } ieh_ctrl_t;

   // status word seen by firmware
   typedef struct packed {
      logic addrFirst;
      logic stopSeen;
      logic arbitrationLostRepeatFlag;
      logic ack;
      logic xmit;
      logic controllerRoleSelect;
      logic busy;
   } ieh_status_t;

   // bus engine events, one-cycle pulses on the link clock
   typedef struct packed {
      logic arbLost;
      logic stop;
      logic byteDone;
      logic start;
   } ieh_evt_t;

   localparam ieh_ctrl_t CTRL_RST = ieh_ctrl_t'(4'h8);  // ack set, all else clear

endpackage

// ===== hw/ieh_sync.sv
`timescale 1ns/10ps
module ieh_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_b,
   // level in from another domain, level out
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] q_reg;

   // two flops; the first one feeds only the second
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_reg <= '0;
         q_reg    <= '0;
      end else begin
         meta_reg <= d;
         q_reg    <= meta_reg;
      end
   end

   assign q = q_reg;

endmodule // ieh_sync

// ===== hw/ieh_link.sv
`timescale 1ns/10ps
module ieh_link (
   // link clock and reset
   input  wire logic                 clk_link,
   input  wire logic                 rst_b,
   // bus engine, link domain
   input  wire ieh_pkg::ieh_evt_t    evt,
   input  wire logic [7:0]           rxByte,
   input  wire logic                 ackIn,
   // levels from the system domain
   input  wire logic                 ceSys,
   input  wire logic                 grantTgl,
   input  wire logic                 stopReq,
   // toward the system domain and the bus
   output logic [ieh_pkg::EVT_W-1:0] evtTgl,
   output logic [7:0]                rxHold,
   output logic                      ackHold,
   output logic                      sclHoldLow,
   output logic                      stopIssue
);

   logic [ieh_pkg::LINK_SYNC_W-1:0] lvlSync;
   logic                            ceL;
   logic                            grantL;
   logic                            stopL;
   logic [ieh_pkg::EVT_W-1:0]       tgl_reg, tgl_next;
   logic [7:0]                      rx_reg, rx_next;
   logic                            ack_reg, ack_next;
   logic                            inXfer_reg, inXfer_next;
   logic                            waitFw_reg, waitFw_next;
   logic                            grantSeen_reg, grantSeen_next;
   logic                            hold_reg, hold_next;
   logic                            stopIss_reg, stopIss_next;

   // system levels cross on two flops
   ieh_sync #(.W(ieh_pkg::LINK_SYNC_W)) uLvlSync (
      .clk   (clk_link),
      .rst_b (rst_b),
      .d     ({ceSys, grantTgl, stopReq}),
      .q     (lvlSync)
   );
   assign ceL    = lvlSync[2];
   assign grantL = lvlSync[1];
   assign stopL  = lvlSync[0];

   ////////////////////////////////////////////////////////////////////////////
   // events to toggles, bus stretch while firmware is served

   // a grant is a toggle, so a short proceed pulse is never missed
   always_comb begin
      tgl_next       = tgl_reg;
      rx_next        = rx_reg;
      ack_next       = ack_reg;
      inXfer_next    = inXfer_reg;
      waitFw_next    = waitFw_reg;
      grantSeen_next = grantSeen_reg;
      stopIss_next   = stopIss_reg;
      if (ceL) begin
         grantSeen_next = grantL;
         if (grantL != grantSeen_reg) waitFw_next = 1'b0;
         if (evt.start) inXfer_next = 1'b1;
         if (evt.byteDone) begin
            rx_next  = rxByte;  // held until the next byte
            ack_next = ackIn;
            if (inXfer_reg) waitFw_next = 1'b1;
         end
         if (evt.stop) begin
            inXfer_next = 1'b0;
            waitFw_next = 1'b0;
         end
         tgl_next     = tgl_reg ^ evt;
         stopIss_next = stopL;
      end
      hold_next = waitFw_next;
   end

   always_ff @(posedge clk_link or negedge rst_b) begin
      if (!rst_b) begin
         tgl_reg       <= '0;
         rx_reg        <= ieh_pkg::DATA_RST;
         ack_reg       <= 1'b0;
         inXfer_reg    <= 1'b0;
         waitFw_reg    <= 1'b0;
         grantSeen_reg <= 1'b0;
         hold_reg      <= 1'b0;
         stopIss_reg   <= 1'b0;
      end else begin
         tgl_reg       <= tgl_next;
         rx_reg        <= rx_next;
         ack_reg       <= ack_next;
         inXfer_reg    <= inXfer_next;
         waitFw_reg    <= waitFw_next;
         grantSeen_reg <= grantSeen_next;
         hold_reg      <= hold_next;
         stopIss_reg   <= stopIss_next;
      end
   end

   assign evtTgl     = tgl_reg;
   assign rxHold     = rx_reg;
   assign ackHold    = ack_reg;
   assign sclHoldLow = hold_reg;
   assign stopIssue  = stopIss_reg;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   holdLow_a: assert property (
      @(posedge clk_link) disable iff (!rst_b)
      evt.byteDone && inXfer_reg && ceL |=> sclHoldLow)
      else $error("clock not held after byte");

   holdEnd_a: assert property (
      @(posedge clk_link) disable iff (!rst_b)
      evt.stop && ceL |=> !sclHoldLow)
      else $error("clock still held after stop");

endmodule // ieh_link

// ===== test/ieh_bus_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// stand-in for the two-wire bus engine and the parties beyond it
module ieh_bus_model (
   // link clock and the stretch request from the controller
   input  wire logic         clk_link,
   input  wire logic         sclHoldLow,
   // bus events toward the controller
   output ieh_pkg::ieh_evt_t evt,
   output logic [7:0]        rxByte,
   output logic              ackIn
);
   // quiet bus at time zero
   initial begin
      evt    = '0;
      rxByte = 8'h5A;
      ackIn  = 1'b0;
   end

   // one event pulse; a byte waits up to 200 link cycles for the clock stretch to end
   task automatic pulse(input ieh_pkg::ieh_evt_t e, input logic [7:0] b, input logic a);
      int i;
      i = 0;
      while (e.byteDone && sclHoldLow !== 1'b0 && i < 200) begin
         @(posedge clk_link);
         i++;
      end
      @(posedge clk_link);
      evt    <= e;
      rxByte <= b;
      ackIn  <= a;
      @(posedge clk_link);
      evt    <= '0;
      rxByte <= ~b;  // stale byte must never look valid
      ackIn  <= ~a;
      repeat (3) @(posedge clk_link);
   endtask
endmodule // ieh_bus_model

// ===== test/ieh_core_tb.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// firmware-side sequences against the event handshake core
module ieh_core_tb;
   localparam ieh_pkg::ieh_evt_t evStart = ieh_pkg::ieh_evt_t'(4'h1);
   localparam ieh_pkg::ieh_evt_t evByte  = ieh_pkg::ieh_evt_t'(4'h2);
   localparam ieh_pkg::ieh_evt_t evStop  = ieh_pkg::ieh_evt_t'(4'h4);
   localparam ieh_pkg::ieh_evt_t evArb   = ieh_pkg::ieh_evt_t'(4'h8);

   logic                 clk_sys;
   logic                 clk_link;
   logic                 rst_b;
   logic                 ce;
   logic                 ctrlWr;
   logic                 dataWr;
   logic                 intEnable;
   ieh_pkg::ieh_ctrl_t   ctrlIn;
   logic [7:0]           dataIn;
   ieh_pkg::ieh_status_t status;
   logic [7:0]           dataOut;
   logic                 irq;
   logic [15:0]          irqVector;
   ieh_pkg::ieh_evt_t    evt;
   logic [7:0]           rxByte;
   logic                 ackIn;
   logic                 sclHoldLow;
   logic                 stopIssue;
   logic [7:0]           txByte;
   logic                 ackOut;
   logic                 xmitOut;
   int                   n_mismatch;
   int                   check_count;

   ieh_core u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .ctrlWr(ctrlWr),
      .ctrlIn(ctrlIn), .dataWr(dataWr), .dataIn(dataIn), .intEnable(intEnable),
      .status(status), .dataOut(dataOut), .irq(irq), .irqVector(irqVector),
      .clk_link(clk_link), .linkEvt(evt), .linkRxByte(rxByte), .linkAckIn(ackIn),
      .sclHoldLow(sclHoldLow), .stopIssue(stopIssue), .txByte(txByte),
      .ackOut(ackOut), .xmitOut(xmitOut));

   ieh_bus_model u_bus (.clk_link(clk_link), .sclHoldLow(sclHoldLow), .evt(evt),
      .rxByte(rxByte), .ackIn(ackIn));

   ////////////////////////////////////////////////////////////////////////////
   // clocks: link clock offset so the two never line up
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial begin
      clk_link = 1'b0;
      #17;
      forever #62.5 clk_link = ~clk_link;
   end

   ////////////////////////////////////////////////////////////////////////////
   // checking and closing
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // 0 irq up, 1 stretch released, 2 stop requested, 3 stop request gone
   function automatic logic cond(input int code);
      case (code)
         0: cond = irq;
         1: cond = ~sclHoldLow;
         2: cond = stopIssue;
         default: cond = ~stopIssue;
      endcase
   endfunction

   // bounded wait, sampled on the falling edge where outputs have settled
   task automatic waitFor(input int code);
      int i;
      for (i = 0; i < 2000; i++) begin
         @(negedge clk_sys);
         if (cond(code) === 1'b1) return;
      end
      n_mismatch++;
      $display("MISMATCH wait %0d expected 1 seen 0", code);
      summarize();
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // firmware accesses, one-cycle write strobes
   task automatic ctrl(input logic a, input logic x, input logic r, input logic p);
      @(posedge clk_sys);
      ctrlWr <= 1'b1;
      ctrlIn <= ieh_pkg::ieh_ctrl_t'({a, x, r, p});
      @(posedge clk_sys);
      ctrlWr <= 1'b0;
   endtask

   task automatic wdata(input logic [7:0] b);
      @(posedge clk_sys);
      dataWr <= 1'b1;
      dataIn <= b;
      @(posedge clk_sys);
      dataWr <= 1'b0;
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      n_mismatch = 0;
      check_count = 0;
      rst_b = 1'b0;
      ce = 1'b1;
      ctrlWr = 1'b0;
      dataWr = 1'b0;
      intEnable = 1'b1;
      ctrlIn = ieh_pkg::CTRL_RST;
      dataIn = 8'h00;
      // reset spans both clocks so the link side is cleared too
      repeat (16) @(posedge clk_sys);
      repeat (2) @(posedge clk_link);
      @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk_link);
      idle(1);
      chk("status", 16'(status), 16'h0008);
      chk("irq", irq, 0);
      chk("vector", irqVector, 16'h0018);
      chk("hold", sclHoldLow, 0);

      // enable low: a firmware write is lost and nothing moves
      @(posedge clk_sys);
      ce <= 1'b0;
      ctrl(1'b1, 1'b1, 1'b1, 1'b1);
      idle(2);
      chk("frozen", 16'(status), 16'h0008);
      @(posedge clk_sys);
      ce <= 1'b1;
      repeat (4) @(posedge clk_link);

      // slave receive: address byte, data byte, stop
      u_bus.pulse(evStart, 8'h00, 1'b0);
      u_bus.pulse(evByte, 8'hA5, 1'b1);
      waitFor(0);
      chk("addrFirst", status.addrFirst, 1);
      chk("busy", status.busy, 0);
      chk("dataOut", dataOut, 16'h00A5);
      chk("hold", sclHoldLow, 1);
      ctrl(1'b1, 1'b0, 1'b0, 1'b1);
      waitFor(1);
      chk("irq", irq, 0);
      u_bus.pulse(evByte, 8'h3C, 1'b1);
      waitFor(0);
      chk("addrFirst", status.addrFirst, 0);
      chk("dataOut", dataOut, 16'h003C);
      ctrl(1'b1, 1'b0, 1'b0, 1'b1);
      u_bus.pulse(evStop, 8'h00, 1'b0);
      waitFor(0);
      chk("stopSeen", status.stopSeen, 1);
      ctrl(1'b1, 1'b0, 1'b0, 1'b0);

      // slave transmit: master refuses the first byte, takes the second
      u_bus.pulse(evStart, 8'h00, 1'b0);
      u_bus.pulse(evByte, 8'h51, 1'b1);
      waitFor(0);
      wdata(8'hC3);
      ctrl(1'b1, 1'b1, 1'b0, 1'b1);
      idle(2);
      chk("txByte", txByte, 16'h00C3);
      chk("xmit", xmitOut, 1);
      u_bus.pulse(evByte, 8'h00, 1'b0);
      waitFor(0);
      chk("ackSeen", status.ack, 0);
      chk("busy", status.busy, 0);
      wdata(8'h7E);
      ctrl(1'b1, 1'b1, 1'b0, 1'b1);
      u_bus.pulse(evByte, 8'h00, 1'b1);
      waitFor(0);
      chk("ackSeen", status.ack, 1);
      ctrl(1'b1, 1'b0, 1'b0, 1'b1);
      u_bus.pulse(evStop, 8'h00, 1'b0);
      idle(100);
      ctrl(1'b1, 1'b0, 1'b0, 1'b0);

      // ack withdrawn during receive: the stop stays silent
      u_bus.pulse(evStart, 8'h00, 1'b0);
      u_bus.pulse(evByte, 8'h11, 1'b1);
      waitFor(0);
      ctrl(1'b0, 1'b0, 1'b0, 1'b1);
      waitFor(1);
      chk("ackOut", ackOut, 0);
      u_bus.pulse(evStop, 8'h00, 1'b0);
      idle(300);
      chk("irq", irq, 0);
      chk("stopSeen", status.stopSeen, 0);
      ctrl(1'b1, 1'b0, 1'b0, 1'b0);

      // interrupt masked: event still recorded, pin follows the enable
      intEnable <= 1'b0;
      u_bus.pulse(evStart, 8'h00, 1'b0);
      u_bus.pulse(evByte, 8'h22, 1'b1);
      idle(300);
      chk("irq", irq, 0);
      chk("dataOut", dataOut, 16'h0022);
      @(posedge clk_sys);
      intEnable <= 1'b1;
      idle(3);
      chk("irq", irq, 1);
      ctrl(1'b1, 1'b0, 1'b0, 1'b1);
      u_bus.pulse(evStop, 8'h00, 1'b0);
      waitFor(0);
      ctrl(1'b1, 1'b0, 1'b0, 1'b0);

      // master transmit, one byte, then stop by dropping the role
      wdata(8'h9A);
      ctrl(1'b1, 1'b1, 1'b1, 1'b1);
      u_bus.pulse(evStart, 8'h00, 1'b0);
      chk("txByte", txByte, 16'h009A);
      u_bus.pulse(evByte, 8'h00, 1'b1);
      waitFor(0);
      chk("busy", status.busy, 0);
      chk("role", status.controllerRoleSelect, 1);
      ctrl(1'b1, 1'b1, 1'b0, 1'b0);
      waitFor(2);
      u_bus.pulse(evStop, 8'h00, 1'b0);
      waitFor(3);
      ctrl(1'b1, 1'b0, 1'b0, 1'b0);

      // master receive, one byte, stop together with proceed
      // the address byte goes out first, then the direction turns
      ctrl(1'b1, 1'b1, 1'b1, 1'b1);
      u_bus.pulse(evStart, 8'h00, 1'b0);
      u_bus.pulse(evByte, 8'h00, 1'b1);
      waitFor(0);
      ctrl(1'b1, 1'b0, 1'b1, 1'b1);
      u_bus.pulse(evByte, 8'h6E, 1'b1);
      waitFor(0);
      chk("dataOut", dataOut, 16'h006E);
      chk("busy", status.busy, 0);
      ctrl(1'b0, 1'b0, 1'b0, 1'b1);
      waitFor(2);
      u_bus.pulse(evStop, 8'h00, 1'b0);
      waitFor(3);
      chk("stopSeen", status.stopSeen, 0);
      chk("irq", irq, 0);
      ctrl(1'b1, 1'b0, 1'b0, 1'b0);

      // arbitration lost: flags at once, interrupt only after the stop
      ctrl(1'b1, 1'b1, 1'b1, 1'b1);
      u_bus.pulse(evStart, 8'h00, 1'b0);
      u_bus.pulse(evArb, 8'h00, 1'b0);
      idle(200);
      chk("role", status.controllerRoleSelect, 0);
      chk("arbLost", status.arbitrationLostRepeatFlag, 1);
      chk("irq", irq, 0);
      u_bus.pulse(evStop, 8'h00, 1'b0);
      waitFor(0);
      ctrl(1'b1, 1'b0, 1'b0, 1'b0);
      idle(20);
      summarize();
   end
endmodule // ieh_core_tb
